// file: design/sewr_pkg.sv
/*
 * Shared constants, state encoding and check-bit functions for the
 * serial EEPROM write/read command logic.
 * Assumes a 200 MHz system clock and a free-running link sampling clock.
 */
package sewr_pkg;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int CLK_SYS_NS  = 5;
   localparam int T_WRITE_US  = 1000;
   localparam int TW_CYC      = T_WRITE_US * 1000 / CLK_SYS_NS;

   // -------------------------------------------------------------
   // Geometry and field positions
   // -------------------------------------------------------------
   localparam int MEM_AW      = 15;
   localparam int PAGE_AW     = 6;
   localparam int PAGE_BYTES  = 64;
   localparam int WORDS_PAGE  = 16;
   localparam int INC_W       = 7;
   localparam int ECC_W       = 6;
   localparam int ID_SEL_ABIT = 2;
   localparam int LOCK_DBIT   = 1;
   localparam logic [3:0] TYPE_MEM = 4'hA;
   localparam logic [3:0] TYPE_ID  = 4'hB;
   localparam logic [3:0] BITS_BYTE = 4'h8;
   localparam logic [7:0] ERASED   = 8'hFF;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_DEVSEL = 3'b001,
      ST_ADDRH  = 3'b011,
      ST_ADDRL  = 3'b010,
      ST_WDATA  = 3'b110,
      ST_RDATA  = 3'b111
   } sewr_state_e;

   // -------------------------------------------------------------
   // Check bits: xor of the code positions of every set data bit
   // -------------------------------------------------------------
   function automatic logic [ECC_W-1:0] sewr_ecc_gen(input logic [31:0] d);
      logic [ECC_W-1:0] c;
      int               k;
      c = '0;
      k = 0;
      for (int p = 3; p < 39; p++)
      begin
         if ((p & (p - 1)) != 0)
         begin
            if (d[k])
               c = c ^ p[ECC_W-1:0];
            k++;
         end
      end
      return c;
   endfunction

   function automatic logic [31:0] sewr_ecc_fix(input logic [31:0] d,
                                                input logic [ECC_W-1:0] c);
      logic [ECC_W-1:0] syn;
      logic [31:0]      q;
      int               k;
      syn = sewr_ecc_gen(d) ^ c;
      q   = d;
      k   = 0;
      for (int p = 3; p < 39; p++)
      begin
         if ((p & (p - 1)) != 0)
         begin
            if (p[ECC_W-1:0] == syn)
               q[k] = ~q[k];
            k++;
         end
      end
      return q;
   endfunction

   localparam logic [ECC_W-1:0] ERASED_CHK = sewr_ecc_gen(32'hFFFFFFFF);

endpackage

// file: design/sewr_wcycle.sv
/*
 * Internal write cycle timer on the system clock.
 * Assumes req_tgl flips once per cycle request from the link domain.
 */
module sewr_wcycle
   import sewr_pkg::*;
#(
   parameter int TW_CYCLES = TW_CYC
)
(
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic req_tgl,
   output logic      done_tgl
);

   localparam int CW = $clog2(TW_CYCLES + 1);

   logic          req_m_reg;
   logic          req_s_reg;
   logic          req_d_reg;
   logic          active_reg;
   logic [CW-1:0] cnt_reg;
   logic          done_reg;

   assign done_tgl = done_reg;

   // -------------------------------------------------------------
   // Request crossing
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         req_m_reg <= 1'b0;
         req_s_reg <= 1'b0;
         req_d_reg <= 1'b0;
      end
      else
      begin
         req_m_reg <= req_tgl;
         req_s_reg <= req_m_reg;
         req_d_reg <= req_s_reg;
      end
   end

   // -------------------------------------------------------------
   // Cycle timer
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         active_reg <= 1'b0;
         cnt_reg    <= '0;
         done_reg   <= 1'b0;
      end
      else if (req_s_reg ^ req_d_reg)
      begin
         active_reg <= 1'b1;
         cnt_reg    <= '0;
      end
      else if (active_reg)
      begin
         if (cnt_reg == CW'(TW_CYCLES - 1))
         begin
            active_reg <= 1'b0;
            done_reg   <= ~done_reg;
         end
         else
            cnt_reg <= cnt_reg + 1'b1;
      end
   end

   a_cycle_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
      active_reg && cnt_reg == CW'(TW_CYCLES - 1)
      |=> !active_reg && $changed(done_reg))
      else $error("write cycle did not end at its length");

endmodule // sewr_wcycle

// file: design/sewr_ctrl.sv
/*
 * Serial bus command logic of a two-wire EEPROM slave: writes, ID page,
 * lock, polling, reads, check-bit correction.
 * Assumes clk_link is free running and at least six times the bit rate.
 */
module sewr_ctrl
   import sewr_pkg::*;
#(
   parameter int AW        = MEM_AW,
   parameter int TW_CYCLES = TW_CYC
)
(
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic clk_link,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe,
   input  wire logic write_inhibit_in,
   input  wire logic chip_sel_strap_0,
   input  wire logic chip_sel_strap_1,
   input  wire logic chip_sel_strap_2
);

   localparam int DEPTH = 2 ** AW;
   localparam int RW_W  = AW - PAGE_AW;

   // -------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------
   logic [2:0]       scl_sy_reg;
   logic [2:0]       sda_sy_reg;
   logic [1:0]       inh_sy_reg;
   logic [2:0]       strap_m_reg;
   logic [2:0]       strap_s_reg;
   logic [2:0]       done_sy_reg;
   logic             scl_s;
   logic             sda_s;
   logic             inh_s;
   logic             start_det;
   logic             stop_det;
   logic             rise;
   logic             fall;
   logic             done_pulse;
   logic             done_tgl;
   sewr_state_e      state_reg;
   logic [3:0]       bit_cnt_reg;
   logic             ack_ph_reg;
   logic             ack_ok_reg;
   logic [7:0]       shift_reg;
   logic             oe_reg;
   logic [AW-1:0]    addr_reg;
   logic [7:0]       ahi_reg;
   logic             id_sel_reg;
   logic             rw_reg;
   logic             busy_reg;
   logic             req_tgl_reg;
   logic             dacked_reg;
   logic             wid_reg;
   logic             wlock_reg;
   logic             lock_reg;
   logic [RW_W-1:0]  prow_reg;
   logic [7:0]       pbuf_reg [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] pmask_reg;
   logic [7:0]       mem_reg [DEPTH];
   logic [ECC_W-1:0] chk_reg [DEPTH/4];
   logic [7:0]       idpg_reg [PAGE_BYTES];
   logic             sel_ok;
   logic             wr_ok;
   logic             ack_dec;
   logic             trig;
   logic [31:0]      rd_fix;
   logic [7:0]       rd_byte;

   assign sda_out = 1'b0;
   assign sda_oe  = oe_reg;
   assign scl_s   = scl_sy_reg[1];
   assign sda_s   = sda_sy_reg[1];
   assign inh_s   = inh_sy_reg[1];

   // -------------------------------------------------------------
   // Pin synchronisers and bus conditions
   // -------------------------------------------------------------
   always_ff @(posedge clk_link or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_sy_reg  <= 3'h7;
         sda_sy_reg  <= 3'h7;
         inh_sy_reg  <= 2'h0;
         strap_m_reg <= 3'h0;
         strap_s_reg <= 3'h0;
         done_sy_reg <= 3'h0;
      end
      else
      begin
         scl_sy_reg  <= {scl_sy_reg[1:0], scl_in};
         sda_sy_reg  <= {sda_sy_reg[1:0], sda_in};
         inh_sy_reg  <= {inh_sy_reg[0], write_inhibit_in};
         strap_m_reg <= {chip_sel_strap_2, chip_sel_strap_1,
                         chip_sel_strap_0};
         strap_s_reg <= strap_m_reg;
         done_sy_reg <= {done_sy_reg[1:0], done_tgl};
      end
   end

   // Third stage holds the previous level for edge detection
   assign start_det  = scl_s && scl_sy_reg[2] && sda_sy_reg[2] && !sda_s;
   assign stop_det   = scl_s && scl_sy_reg[2] && !sda_sy_reg[2] && sda_s;
   assign rise       = scl_s && !scl_sy_reg[2];
   assign fall       = !scl_s && scl_sy_reg[2];
   assign done_pulse = done_sy_reg[2] ^ done_sy_reg[1];

   // -------------------------------------------------------------
   // Read path with correction
   // -------------------------------------------------------------
   always_comb
   begin
      rd_fix = sewr_ecc_fix({mem_reg[{addr_reg[AW-1:2], 2'h3}],
                             mem_reg[{addr_reg[AW-1:2], 2'h2}],
                             mem_reg[{addr_reg[AW-1:2], 2'h1}],
                             mem_reg[{addr_reg[AW-1:2], 2'h0}]},
                            chk_reg[addr_reg[AW-1:2]]);
      rd_byte = id_sel_reg ? idpg_reg[addr_reg[PAGE_AW-1:0]]
                           : rd_fix[{addr_reg[1:0], 3'h0} +: 8];
   end

   // -------------------------------------------------------------
   // Acknowledge decision
   // -------------------------------------------------------------
   always_comb
   begin
      sel_ok = (shift_reg[7:4] == TYPE_MEM || shift_reg[7:4] == TYPE_ID)
               && shift_reg[3:1] == strap_s_reg;
      wr_ok  = !inh_s && !(id_sel_reg && lock_reg);
      case (state_reg)
         ST_DEVSEL: ack_dec = sel_ok;
         ST_ADDRH:  ack_dec = 1'b1;
         ST_ADDRL:  ack_dec = 1'b1;
         ST_WDATA:  ack_dec = wr_ok;
         default:   ack_dec = 1'b0;
      endcase
   end

   // Stop in the slot right after a data byte ack
   assign trig = stop_det && state_reg == ST_WDATA && !ack_ph_reg
                 && bit_cnt_reg <= 4'h1 && dacked_reg
                 && (|pmask_reg || wlock_reg);

   // -------------------------------------------------------------
   // Bus protocol
   // -------------------------------------------------------------
   always_ff @(posedge clk_link or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg   <= ST_IDLE;
         bit_cnt_reg <= 4'h0;
         ack_ph_reg  <= 1'b0;
         ack_ok_reg  <= 1'b0;
         shift_reg   <= 8'h00;
         oe_reg      <= 1'b0;
         addr_reg    <= '0;
         ahi_reg     <= 8'h00;
         id_sel_reg  <= 1'b0;
         rw_reg      <= 1'b0;
         busy_reg    <= 1'b0;
         req_tgl_reg <= 1'b0;
         dacked_reg  <= 1'b0;
         wid_reg     <= 1'b0;
         wlock_reg   <= 1'b0;
         prow_reg    <= '0;
         pmask_reg   <= '0;
         for (int i = 0; i < PAGE_BYTES; i++)
            pbuf_reg[i] <= ERASED;
      end
      else if (busy_reg)
      begin
         // Bus fully ignored while programming
         state_reg <= ST_IDLE;
         oe_reg    <= 1'b0;
         if (done_pulse)
         begin
            busy_reg  <= 1'b0;
            pmask_reg <= '0;
            wlock_reg <= 1'b0;
            addr_reg  <= {addr_reg[AW-1:INC_W], addr_reg[INC_W-1:0]};
         end
      end
      else if (start_det)
      begin
         state_reg   <= ST_DEVSEL;
         bit_cnt_reg <= 4'h0;
         ack_ph_reg  <= 1'b0;
         oe_reg      <= 1'b0;
         pmask_reg   <= '0;
         wlock_reg   <= 1'b0;
         dacked_reg  <= 1'b0;
      end
      else if (stop_det)
      begin
         state_reg <= ST_IDLE;
         oe_reg    <= 1'b0;
         if (trig)
         begin
            busy_reg    <= 1'b1;
            req_tgl_reg <= ~req_tgl_reg;
         end
      end
      else if (state_reg == ST_RDATA)
      begin
         if (rise && !ack_ph_reg)
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         else if (fall && !ack_ph_reg)
         begin
            if (bit_cnt_reg == BITS_BYTE)
            begin
               oe_reg     <= 1'b0;
               ack_ph_reg <= 1'b1;
            end
            else
            begin
               oe_reg    <= ~shift_reg[6];
               shift_reg <= {shift_reg[6:0], 1'b0};
            end
         end
         else if (rise && ack_ph_reg)
         begin
            addr_reg <= addr_reg + 1'b1;
            if (sda_s)
            begin
               state_reg  <= ST_IDLE;
               ack_ph_reg <= 1'b0;
            end
         end
         else if (fall && ack_ph_reg)
         begin
            ack_ph_reg  <= 1'b0;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= rd_byte;
            oe_reg      <= ~rd_byte[7];
         end
      end
      else if (state_reg != ST_IDLE)
      begin
         if (rise && !ack_ph_reg)
         begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         end
         else if (fall && !ack_ph_reg && bit_cnt_reg == BITS_BYTE)
         begin
            ack_ph_reg <= 1'b1;
            ack_ok_reg <= ack_dec;
            oe_reg     <= ack_dec;
            case (state_reg)
               ST_DEVSEL:
               begin
                  id_sel_reg <= shift_reg[7:4] == TYPE_ID;
                  rw_reg     <= shift_reg[0];
               end
               ST_ADDRH:
                  ahi_reg <= shift_reg;
               ST_ADDRL:
                  addr_reg <= AW'({ahi_reg, shift_reg});
               ST_WDATA:
                  if (ack_dec)
                  begin
                     dacked_reg <= 1'b1;
                     wid_reg    <= id_sel_reg;
                     if (id_sel_reg && ahi_reg[ID_SEL_ABIT])
                        wlock_reg <= wlock_reg
                                     | shift_reg[LOCK_DBIT];
                     else
                     begin
                        pbuf_reg[addr_reg[PAGE_AW-1:0]] <= shift_reg;
                        pmask_reg[addr_reg[PAGE_AW-1:0]] <= 1'b1;
                        if (pmask_reg == '0)
                           prow_reg <= addr_reg[AW-1:PAGE_AW];
                        addr_reg <= {addr_reg[AW-1:INC_W],
                                     addr_reg[INC_W-1:0]
                                     + 1'b1};
                     end
                  end
               default:
                  ahi_reg <= ahi_reg;
            endcase
         end
         else if (fall && ack_ph_reg)
         begin
            ack_ph_reg  <= 1'b0;
            bit_cnt_reg <= 4'h0;
            oe_reg      <= 1'b0;
            if (!ack_ok_reg)
               state_reg <= ST_IDLE;
            else if (state_reg == ST_DEVSEL && rw_reg)
            begin
               state_reg <= ST_RDATA;
               shift_reg <= rd_byte;
               oe_reg    <= ~rd_byte[7];
            end
            else if (state_reg == ST_DEVSEL)
               state_reg <= ST_ADDRH;
            else if (state_reg == ST_ADDRH)
               state_reg <= ST_ADDRL;
            else
               state_reg <= ST_WDATA;
         end
      end
   end

   // -------------------------------------------------------------
   // Array commit at the end of the write cycle
   // -------------------------------------------------------------
   always_ff @(posedge clk_link or negedge rst_n)
   begin : commit
      logic [31:0] old_w;
      logic [31:0] new_w;
      if (!rst_n)
      begin
         lock_reg <= 1'b0;
         for (int i = 0; i < DEPTH; i++)
            mem_reg[i] <= ERASED;
         for (int i = 0; i < DEPTH / 4; i++)
            chk_reg[i] <= ERASED_CHK;
         for (int i = 0; i < PAGE_BYTES; i++)
            idpg_reg[i] <= ERASED;
      end
      else if (done_pulse && busy_reg)
      begin
         if (wid_reg && wlock_reg)
            lock_reg <= 1'b1;
         else if (wid_reg)
         begin
            for (int i = 0; i < PAGE_BYTES; i++)
               if (pmask_reg[i])
                  idpg_reg[i] <= pbuf_reg[i];
         end
         else
            for (int w = 0; w < WORDS_PAGE; w++)
            begin
               if (|pmask_reg[4*w +: 4])
               begin
                  // Old word corrected first so a latent flip is not kept
                  old_w = sewr_ecc_fix(
                     {mem_reg[{prow_reg, w[3:0], 2'h3}],
                      mem_reg[{prow_reg, w[3:0], 2'h2}],
                      mem_reg[{prow_reg, w[3:0], 2'h1}],
                      mem_reg[{prow_reg, w[3:0], 2'h0}]},
                     chk_reg[{prow_reg, w[3:0]}]);
                  for (int b = 0; b < 4; b++)
                  begin
                     new_w[8*b +: 8] = pmask_reg[4*w + b]
                                       ? pbuf_reg[4*w + b]
                                       : old_w[8*b +: 8];
                     mem_reg[{prow_reg, w[3:0], b[1:0]}]
                        <= new_w[8*b +: 8];
                  end
                  chk_reg[{prow_reg, w[3:0]}] <= sewr_ecc_gen(new_w);
               end
            end
      end
   end

   // -------------------------------------------------------------
   // Write cycle timer on the system clock
   // -------------------------------------------------------------
   sewr_wcycle #(
      .TW_CYCLES (TW_CYCLES)
   ) u_wcycle (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .req_tgl  (req_tgl_reg),
      .done_tgl (done_tgl)
   );

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   sequence s_rd_slot;
      state_reg == ST_RDATA && ack_ph_reg && rise && !busy_reg
      && !start_det && !stop_det;
   endsequence

   a_busy_quiet: assert property (@(posedge clk_link) disable iff (!rst_n)
      busy_reg |=> !sda_oe)
      else $error("bus driven during write cycle");

   a_sel_match: assert property (@(posedge clk_link) disable iff (!rst_n)
      $rose(ack_ph_reg) && $past(state_reg) == ST_DEVSEL && sda_oe
      |-> shift_reg[3:1] == strap_s_reg && shift_reg[7:5] == 3'h5)
      else $error("select code acked without a match");

   a_inhibit_nack: assert property (@(posedge clk_link) disable iff (!rst_n)
      $rose(ack_ph_reg) && state_reg == ST_WDATA && $past(inh_s)
      |-> !sda_oe)
      else $error("data acked while write inhibited");

   a_locked_nack: assert property (@(posedge clk_link) disable iff (!rst_n)
      $rose(ack_ph_reg) && state_reg == ST_WDATA && id_sel_reg
      && $past(lock_reg) |-> !sda_oe)
      else $error("locked page data acked");

   a_stop_trigger: assert property (@(posedge clk_link) disable iff (!rst_n)
      $rose(busy_reg) |-> $past(stop_det) && $past(state_reg) == ST_WDATA
      && $past(dacked_reg))
      else $error("write cycle started without data stop");

   a_row_hold: assert property (@(posedge clk_link) disable iff (!rst_n)
      state_reg == ST_WDATA && $past(state_reg) == ST_WDATA
      && !$past(busy_reg)
      |-> addr_reg[AW-1:INC_W] == $past(addr_reg[AW-1:INC_W]))
      else $error("row bits moved during page write");

   a_read_advance: assert property (@(posedge clk_link) disable iff (!rst_n)
      s_rd_slot |=> addr_reg == AW'($past(addr_reg) + 1'b1))
      else $error("read did not advance the counter");

   a_master_nack: assert property (@(posedge clk_link) disable iff (!rst_n)
      s_rd_slot ##0 sda_s |=> state_reg == ST_IDLE ##1 !sda_oe)
      else $error("read went on after master no-ack");

   a_start_discard: assert property (@(posedge clk_link) disable iff (!rst_n)
      start_det && !busy_reg |=> state_reg == ST_DEVSEL && pmask_reg == '0)
      else $error("start did not discard command");

endmodule // sewr_ctrl

// file: dv/sewr_master.sv
/* Bus master model driving the two-wire link.
   Assumes the bench resolves SDA with a pull-up. */
module sewr_master
(
   input  wire logic clk_link,
   input  wire logic sda,
   output logic      scl = 1'b1,
   output logic      sda_m = 1'b1
);
   timeunit 1ns;
   timeprecision 1ps;
   task automatic t(input int n);
      repeat (n) @(negedge clk_link);
   endtask
   // SDA moves only while SCL is low
   task automatic bx(input logic b, output logic r);
      t(1);
      sda_m = b;
      t(2);
      scl = 1'b1;
      t(3);
      r   = sda;
      scl = 1'b0;
   endtask
   // Start when a is 1, stop when a is 0; SCL idles high after stop
   task automatic cond(input logic a);
      t(1);
      sda_m = a;
      t(2);
      scl = 1'b1;
      t(3);
      sda_m = ~a;
      t(3);
      scl = ~a;
   endtask
   task automatic wbyte(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bx(v[i], r);
      bx(1'b1, r);
      ack = ~r;
   endtask
   task automatic rbyte(input logic ack, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--)
         bx(1'b1, v[i]);
      bx(~ack, r);
   endtask
endmodule // sewr_master

// file: dv/test_serial_eeprom_write_read_ctrl.sv
/* Self-checking bench for the EEPROM command logic.
   Assumes the master model owns SCL and SDA has a pull-up. */
module test_serial_eeprom_write_read_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_sys = 1'b0;
   logic       clk_link = 1'b0;
   logic       rst_n = 1'b0;
   logic       write_inhibit_in = 1'b0;
   logic       strap_0 = 1'b1;
   logic       strap_1 = 1'b0;
   logic       strap_2 = 1'b1;
   logic       scl, sda_m, sda_oe, sda_out, a;
   logic [7:0] d;
   wire        sda = ~(sda_oe & ~sda_out) & sda_m;
   int         bad_count = 0;
   int         samples_checked = 0;
   always #2.5 clk_sys = ~clk_sys;
   initial
   begin
      #37;
      forever #80 clk_link = ~clk_link;
   end
   sewr_master m (.clk_link(clk_link), .sda(sda), .scl(scl), .sda_m(sda_m));
   // Short write cycle: two polling selects nack, the third one acks
   sewr_ctrl #(.TW_CYCLES(2500)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
      .clk_link(clk_link), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .write_inhibit_in(write_inhibit_in),
      .chip_sel_strap_0(strap_0), .chip_sel_strap_1(strap_1),
      .chip_sel_strap_2(strap_2));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("FAIL %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wb(input logic [7:0] v, input logic e);
      m.wbyte(v, a);
      chk({7'h00, a}, {7'h00, e});
   endtask
   task automatic hdr(input logic [7:0] s, input logic [15:0] ad);
      m.cond(1'b1);
      wb(s, 1'b1);
      wb(ad[15:8], 1'b1);
      wb(ad[7:0], 1'b1);
   endtask
   task automatic rd(input logic [7:0] e, input logic ak);
      m.rbyte(ak, d);
      chk(d, e);
   endtask
   task automatic poll(input logic [7:0] s, input logic [15:0] ad);
      m.cond(1'b1);
      wb(s, 1'b0);
      for (int i = 0; i < 8 && a !== 1'b1; i++)
      begin
         m.cond(1'b1);
         m.wbyte(s, a);
      end
      chk({7'h00, a}, 8'h01);
      wb(ad[15:8], 1'b1);
      wb(ad[7:0], 1'b1);
   endtask
   task automatic t_write();
      hdr(8'hAA, 16'h0000);
      wb(8'h12, 1'b1);
      wb(8'h34, 1'b1);
      wb(8'h56, 1'b1);
      m.cond(1'b0);
      poll(8'hAA, 16'h7FFF);
      m.cond(1'b1);
      wb(8'hAB, 1'b1);
      rd(8'hFF, 1'b1);
      rd(8'h12, 1'b0);
      m.cond(1'b1);
      wb(8'hAB, 1'b1);
      rd(8'h34, 1'b0);
      m.cond(1'b0);
      $display("write and read test done");
   endtask
   task automatic t_inhibit();
      @(negedge clk_sys) write_inhibit_in = 1'b1;
      hdr(8'hAA, 16'h0001);
      wb(8'h77, 1'b0);
      m.cond(1'b0);
      hdr(8'hAA, 16'h0001);
      m.cond(1'b1);
      wb(8'hAB, 1'b1);
      rd(8'h34, 1'b0);
      m.cond(1'b0);
      @(negedge clk_sys) write_inhibit_in = 1'b0;
      $display("inhibit test done");
   endtask
   task automatic t_sel();
      m.cond(1'b1);
      wb(8'hA0, 1'b0);
      m.cond(1'b1);
      wb(8'h9A, 1'b0);
      m.cond(1'b0);
      $display("select test done");
   endtask
   task automatic t_id();
      hdr(8'hBA, 16'h0005);
      wb(8'hC3, 1'b1);
      m.cond(1'b0);
      poll(8'hBA, 16'hFB05);
      m.cond(1'b1);
      wb(8'hBB, 1'b1);
      rd(8'hC3, 1'b0);
      hdr(8'hBA, 16'h0400);
      wb(8'h02, 1'b1);
      m.cond(1'b0);
      poll(8'hBA, 16'h0005);
      wb(8'h5A, 1'b0);
      m.cond(1'b1);
      m.cond(1'b0);
      hdr(8'hBA, 16'h0400);
      wb(8'h02, 1'b0);
      m.cond(1'b0);
      $display("id page test done");
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(negedge clk_link);
      rst_n = 1'b1;
      m.t(5);
      t_write();
      t_inhibit();
      t_sel();
      t_id();
      close_out();
   end
   // Tests need roughly 500 us of bus traffic
   initial
   begin
      #700us;
      bad_count++;
      close_out();
   end
endmodule // test_serial_eeprom_write_read_ctrl
